// ===== rtl/host_port_pkg.sv
// Purpose: constants and carriers for the register port controller
// Assumes: 200 MHz clock, device pins sampled synchronously
// Notes:   timings are whole cycles of the 5 ns clock
`default_nettype none
package host_port_pkg;
	localparam int CLK_PERIOD_NS       = 5;
	localparam int RESET_PULSE_NS      = 100;
	localparam int RESET_CYCLES        =
		(RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_NS           = 40;
	localparam int STROBE_CYCLES       =
		(STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_NS            = 10;
	localparam int SETUP_CYCLES        =
		(SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_W              = 9;
	localparam int DATA_W              = 8;
	localparam int CNT_W               = 6;
	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 9'h000;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} request_type;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] rdata;
	} reply_type;

	typedef struct packed {
		logic              select_n;
		logic              read_n;
		logic              write_n;
		logic              latch_en;
		logic              reset_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data_out;
		logic              data_oe;
	} pins_type;

	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_PARK  = 3'h1,
		ST_IDLE  = 3'h2,
		ST_SETUP = 3'h3,
		ST_STROBE = 3'h4,
		ST_HOLD  = 3'h5
	} state_type;
endpackage : host_port_pkg
`default_nettype wire

// ===== rtl/irq_watch.sv
// Purpose: registers the open-drain interrupt line level
// Assumes: line pulled up outside; low means asserted
// Notes:   two flops so the level is stable for the controller
`default_nettype none
module irq_watch (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	// Line
	input  wire logic i_irq_n,
	output var  logic o_irq
);
	typedef struct packed {
		logic stage;
		logic level;
	} watch_type;

	watch_type watch;
	watch_type next_watch;

	always_comb begin
		next_watch       = watch;
		next_watch.stage = ~i_irq_n;
		next_watch.level = watch.stage;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			watch <= '0;
		end else begin
			watch <= next_watch;
		end
	end

	assign o_irq = watch.level;
endmodule : irq_watch
`default_nettype wire

// ===== rtl/host_register_port.sv
// Purpose: drives the device register port from a simple request port
// Assumes: device pins synchronous to i_clk, one request at a time
// Notes:   data bus split into in, out and enable
//          read data captured on the last strobe cycle
//          device reset request taken only when idle
//          interrupt line only watched, cleared by user writes
`default_nettype none
// Contract
// - Select held low during every access
// - Select driven high once after power-up
// - Select always driven, never tied
// - Read strobe pulsed low with address shown
// - Reset pin held low at least 100 ns
module host_register_port
	import host_port_pkg::*;
(
	// Clock and reset
	input  wire logic                       i_clk,
	input  wire logic                       i_reset_n,
	// Request side
	input  wire logic                       i_req_valid,
	input  wire host_port_pkg::request_type i_req,
	output var  logic                       o_req_ready,
	output var  host_port_pkg::reply_type   o_reply,
	input  wire logic                       i_dev_reset_req,
	output var  logic                       o_irq,
	// Device pins
	output var  logic                       o_unit_select_n,
	output var  logic                       o_read_strobe_n,
	output var  logic                       o_write_strobe_n,
	output var  logic                       o_addr_latch_en,
	output var  logic                       o_async_reset_n,
	output var  logic [ADDR_W-1:0]          o_addr,
	output var  logic [DATA_W-1:0]          o_data,
	output var  logic                       o_data_oe,
	input  wire logic [DATA_W-1:0]          i_data,
	input  wire logic                       i_irq_out_n
);
	import host_port_pkg::*;

	typedef struct packed {
		state_type         state;
		logic [CNT_W-1:0]  count;
		logic              write;
		pins_type          pins;
		logic              ready;
		reply_type         reply;
	} ctrl_type;

	// Phase lengths in whole clock cycles
	localparam logic [CNT_W-1:0] RESET_CNT  = CNT_W'(RESET_CYCLES);
	localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYCLES);
	localparam logic [CNT_W-1:0] SETUP_CNT  = CNT_W'(SETUP_CYCLES);

	// All controller state in one register
	ctrl_type ctrl;
	ctrl_type next_ctrl;
	logic     count_done;

	irq_watch u_irq_watch (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_irq_n   (i_irq_out_n),
		.o_irq     (o_irq)
	);

	// Counter at zero ends each timed phase
	assign count_done = (ctrl.count == CNT_ZERO);

	always_comb begin
		next_ctrl = ctrl;
		next_ctrl.reply.valid = 1'b0;
		if (!count_done) begin
			next_ctrl.count = ctrl.count - CNT_ONE;
		end
		case (ctrl.state)
			// Device held in reset, all strobes parked high
			ST_RESET: begin
				next_ctrl.ready         = 1'b0;
				next_ctrl.pins.reset_n  = 1'b0;
				next_ctrl.pins.select_n = 1'b1;
				next_ctrl.pins.read_n   = 1'b1;
				next_ctrl.pins.write_n  = 1'b1;
				next_ctrl.pins.latch_en = 1'b1;
				next_ctrl.pins.data_oe  = 1'b0;
				if (count_done) begin
					next_ctrl.pins.reset_n = 1'b1;
					next_ctrl.state        = ST_PARK;
					next_ctrl.count        = SETUP_CNT;
				end
			end

			// Select high after reset clears test modes
			ST_PARK: begin
				next_ctrl.pins.select_n = 1'b1;
				next_ctrl.pins.read_n   = 1'b1;
				next_ctrl.pins.write_n  = 1'b1;
				next_ctrl.pins.data_oe  = 1'b0;
				if (count_done) begin
					next_ctrl.state = ST_IDLE;
					next_ctrl.ready = 1'b1;
				end
			end

			// Device reset request wins over an access
			ST_IDLE: begin
				if (i_dev_reset_req) begin
					next_ctrl.ready         = 1'b0;
					next_ctrl.pins.reset_n  = 1'b0;
					next_ctrl.pins.select_n = 1'b1;
					next_ctrl.state         = ST_RESET;
					next_ctrl.count         = RESET_CNT;
				end else if (i_req_valid) begin
					next_ctrl.ready          = 1'b0;
					next_ctrl.write          = i_req.write;
					next_ctrl.pins.addr      = i_req.addr;
					next_ctrl.pins.latch_en  = 1'b1;
					next_ctrl.pins.data_out  = i_req.wdata;
					next_ctrl.pins.data_oe   = i_req.write;
					next_ctrl.pins.select_n  = 1'b0;
					next_ctrl.state          = ST_SETUP;
					next_ctrl.count          = SETUP_CNT;
				end
			end

			// Address and select settle before the strobe
			ST_SETUP: begin
				if (count_done) begin
					next_ctrl.pins.latch_en = 1'b0;
					next_ctrl.pins.read_n   = ctrl.write;
					next_ctrl.pins.write_n  = ~ctrl.write;
					next_ctrl.state         = ST_STROBE;
					next_ctrl.count         = STROBE_CNT;
				end
			end

			// Read data taken on the last strobe cycle
			ST_STROBE: begin
				if (count_done) begin
					if (!ctrl.write) begin
						next_ctrl.reply.rdata = i_data;
					end
					next_ctrl.pins.read_n  = 1'b1;
					next_ctrl.pins.write_n = 1'b1;
					next_ctrl.state        = ST_HOLD;
					next_ctrl.count        = SETUP_CNT;
				end
			end

			// Address and data held past the strobe edge
			ST_HOLD: begin
				next_ctrl.pins.read_n   = 1'b1;
				next_ctrl.pins.write_n  = 1'b1;
				if (count_done) begin
					next_ctrl.pins.select_n = 1'b1;
					next_ctrl.pins.data_oe  = 1'b0;
					next_ctrl.pins.latch_en = 1'b1;
					next_ctrl.reply.valid   = 1'b1;
					next_ctrl.ready         = 1'b1;
					next_ctrl.state         = ST_IDLE;
				end
			end

			// Unknown state: park pins and reset the device
			default: begin
				next_ctrl.ready         = 1'b0;
				next_ctrl.pins.select_n = 1'b1;
				next_ctrl.pins.read_n   = 1'b1;
				next_ctrl.pins.write_n  = 1'b1;
				next_ctrl.pins.data_oe  = 1'b0;
				next_ctrl.state         = ST_RESET;
				next_ctrl.count         = RESET_CNT;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			// Device held in reset, strobes parked high
			ctrl.state         <= ST_RESET;
			ctrl.count         <= RESET_CNT;
			ctrl.write         <= 1'b0;
			ctrl.pins.select_n <= 1'b1;
			ctrl.pins.read_n   <= 1'b1;
			ctrl.pins.write_n  <= 1'b1;
			ctrl.pins.latch_en <= 1'b1;
			ctrl.pins.reset_n  <= 1'b0;
			ctrl.pins.addr     <= ADDR_ZERO;
			ctrl.pins.data_out <= DATA_ZERO;
			ctrl.pins.data_oe  <= 1'b0;
			ctrl.ready         <= 1'b0;
			ctrl.reply.valid   <= 1'b0;
			ctrl.reply.rdata   <= DATA_ZERO;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// Request side
	assign o_req_ready      = ctrl.ready;
	assign o_reply          = ctrl.reply;

	// Device pins, straight from the state register
	assign o_unit_select_n  = ctrl.pins.select_n;
	assign o_read_strobe_n  = ctrl.pins.read_n;
	assign o_write_strobe_n = ctrl.pins.write_n;
	assign o_addr_latch_en  = ctrl.pins.latch_en;
	assign o_async_reset_n  = ctrl.pins.reset_n;
	assign o_addr           = ctrl.pins.addr;
	assign o_data           = ctrl.pins.data_out;
	assign o_data_oe        = ctrl.pins.data_oe;
endmodule : host_register_port
`default_nettype wire

// ===== tb/host_port_chk.sv
// Purpose: pin checks of the register port controller
// Assumes: one clock, async low reset
// Notes:   sees only top module ports
`default_nettype none
module host_port_chk
	import host_port_pkg::*;
(
	// Clock and reset
	input wire logic              i_clk,
	input wire logic              i_reset_n,
	// Device pins
	input wire logic              o_unit_select_n,
	input wire logic              o_read_strobe_n,
	input wire logic              o_write_strobe_n,
	input wire logic              o_addr_latch_en,
	input wire logic              o_async_reset_n,
	input wire logic              o_data_oe,
	input wire logic [ADDR_W-1:0] o_addr,
	input wire logic [DATA_W-1:0] o_data
);
	logic [CNT_W-1:0] low_cnt;
	// Device reset low time in cycles
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			low_cnt <= CNT_ZERO;
		end else if (o_async_reset_n) begin
			low_cnt <= CNT_ZERO;
		end else if (low_cnt != 6'h3F) begin
			low_cnt <= low_cnt + CNT_ONE;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	a_strobe_needs_select: assert property (
		(!o_read_strobe_n || !o_write_strobe_n) |-> !o_unit_select_n)
		else $error("strobe without select");
	a_select_in_reset: assert property (
		!o_async_reset_n |-> o_unit_select_n) else $error("select in reset");
	a_select_after_reset: assert property (
		$fell(o_unit_select_n) |-> $past(o_async_reset_n, 2))
		else $error("select before reset end");
	a_read_addr_held: assert property (
		!o_read_strobe_n |-> $stable(o_addr) && !o_data_oe && !o_addr_latch_en)
		else $error("read address moved");
	a_write_data_held: assert property (
		!o_write_strobe_n |-> o_data_oe && $stable(o_data) && $stable(o_addr))
		else $error("write data moved");
	a_reset_pulse_width: assert property (
		$rose(o_async_reset_n) |-> low_cnt >= RESET_CYCLES)
		else $error("device reset too short");
endmodule : host_port_chk
bind host_register_port host_port_chk u_host_port_chk (.i_clk(i_clk),
	.i_reset_n(i_reset_n), .o_unit_select_n(o_unit_select_n),
	.o_read_strobe_n(o_read_strobe_n), .o_write_strobe_n(o_write_strobe_n),
	.o_addr_latch_en(o_addr_latch_en), .o_async_reset_n(o_async_reset_n),
	.o_data_oe(o_data_oe), .o_addr(o_addr), .o_data(o_data));
`default_nettype wire

// ===== tb/reg_device_model.sv
// Purpose: behavioural register device on the far side
// Assumes: data bus has no pull, irq line pulled up
// Notes:   write to ACK_ADDR acknowledges the interrupt
`default_nettype none
module reg_device_model
	import host_port_pkg::*;
#(parameter logic [ADDR_W-1:0] ACK_ADDR = 9'h1FF)
(
	// Clock
	input wire logic              i_clk,
	// Controller pins
	input wire logic              i_unit_select_n,
	input wire logic              i_read_strobe_n,
	input wire logic              i_write_strobe_n,
	input wire logic              i_addr_latch_en,
	input wire logic              i_async_reset_n,
	input wire logic              i_host_oe,
	// Interrupt source
	input wire logic              i_event,
	// Buses
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_host_data,
	output var logic [DATA_W-1:0] o_bus,
	output var logic              o_irq_out_n
);
	logic [DATA_W-1:0] mem [512];
	logic [DATA_W-1:0] last = 8'h00;
	logic [ADDR_W-1:0] held;
	logic              armed = 1'b0;
	logic              pend;
	always_latch if (i_addr_latch_en) held = i_addr;
	always @(negedge i_async_reset_n) begin
		foreach (mem[k]) mem[k] = DATA_ZERO;
		pend = 1'b0;
	end
	always @(posedge i_clk) if (i_unit_select_n) armed = 1'b1;
	always @(posedge i_write_strobe_n) begin
		if (!i_unit_select_n && armed && held == ACK_ADDR) pend = 1'b0;
		else if (!i_unit_select_n && armed) mem[held] = o_bus;
	end
	always @(posedge i_event) pend = 1'b1;
	assign o_irq_out_n = !pend;
	// Released bus shows inverse of last value
	always_comb o_bus = i_host_oe ? i_host_data :
		(!i_read_strobe_n && !i_unit_select_n) ? mem[held] : ~last;
	always @(posedge i_clk) last <= o_bus;
endmodule : reg_device_model
`default_nettype wire

// ===== tb/host_register_port_tb.sv
// Purpose: self-checking bench of the register port controller
// Assumes: inputs driven on falling edge
// Notes:   bounded waits end the run on timeout
`default_nettype none
module host_register_port_tb import host_port_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 0, i_reset_n = 0, i_req_valid = 0, dev_req = 0, ev = 0;
	request_type i_req = '0;
	reply_type o_reply;
	logic ready, irq, sel_n, rd_n, wr_n, ale, arst_n, oe, irq_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] dout, bus, rd;
	int errors = 0, checks = 0;
	always #2.5 i_clk = ~i_clk;
	host_register_port u_host_register_port (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .i_req_valid(i_req_valid), .i_req(i_req),
		.o_req_ready(ready), .o_reply(o_reply), .i_dev_reset_req(dev_req),
		.o_irq(irq), .o_unit_select_n(sel_n), .o_read_strobe_n(rd_n),
		.o_write_strobe_n(wr_n), .o_addr_latch_en(ale),
		.o_async_reset_n(arst_n), .o_addr(addr), .o_data(dout),
		.o_data_oe(oe), .i_data(bus), .i_irq_out_n(irq_n));
	reg_device_model u_reg_device_model (.i_clk(i_clk),
		.i_unit_select_n(sel_n), .i_read_strobe_n(rd_n),
		.i_write_strobe_n(wr_n), .i_addr_latch_en(ale),
		.i_async_reset_n(arst_n), .i_host_oe(oe), .i_event(ev),
		.i_addr(addr), .i_host_data(dout), .o_bus(bus), .o_irq_out_n(irq_n));
	task automatic check(logic [7:0] seen, logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic access(logic w, logic [8:0] a, logic [7:0] d);
		int n = 0;
		while (ready !== 1'b1 && n < 100) begin
			@(negedge i_clk);
			n++;
		end
		if (ready !== 1'b1) begin
			errors++;
			$display("CHECK FAILED %0t ready timed out", $time);
			end_of_test();
		end
		i_req = '{w, a, d};
		i_req_valid = 1'b1;
		@(negedge i_clk) i_req_valid = 1'b0;
		n = 0;
		while (o_reply.valid !== 1'b1 && n < 99) begin
			@(negedge i_clk);
			n++;
		end
		if (o_reply.valid !== 1'b1) begin
			errors++;
			$display("CHECK FAILED %0t reply timed out", $time);
			end_of_test();
		end
		rd = o_reply.rdata;
	endtask : access
	task automatic sc_data();
		logic [8:0] a [4] = '{9'h000, 9'h0A5, 9'h15A, 9'h1FE};
		foreach (a[k]) access(1'b1, a[k], a[k][7:0] ^ 8'h3C);
		foreach (a[k]) begin
			access(1'b0, a[k], 8'h00);
			check(rd, a[k][7:0] ^ 8'h3C);
		end
	endtask : sc_data
	task automatic sc_irq();
		@(negedge i_clk) ev = 1'b1;
		repeat (3) @(negedge i_clk);
		check(8'(irq), 8'h01);
		access(1'b0, 9'h000, 8'h00);
		check(8'(irq), 8'h01);
		access(1'b1, 9'h1FF, 8'h01);
		ev = 1'b0;
		repeat (3) @(negedge i_clk);
		check(8'(irq), 8'h00);
	endtask : sc_irq
	task automatic sc_dev_reset();
		int low = 0;
		int n = 0;
		@(negedge i_clk) dev_req = 1'b1;
		@(negedge i_clk) dev_req = 1'b0;
		for (int k = 0; k < 4; k++) begin
			low += (arst_n === 1'b0);
			@(negedge i_clk);
		end
		check(8'(arst_n), 8'h00);
		while (arst_n === 1'b0 && n < 100) begin
			low++;
			@(negedge i_clk);
			n++;
		end
		if (arst_n !== 1'b1) begin
			errors++;
			$display("CHECK FAILED %0t device reset stuck", $time);
			end_of_test();
		end
		check(8'(low >= RESET_CYCLES), 8'h01);
		access(1'b0, 9'h0A5, 8'h00);
		check(rd, 8'h00);
	endtask : sc_dev_reset
	initial begin
		repeat (16) @(negedge i_clk);
		i_reset_n = 1'b1;
		sc_data();
		sc_irq();
		sc_dev_reset();
		end_of_test();
	end
endmodule : host_register_port_tb
`default_nettype wire
